// >>> verilog/txdw_port.sv
/*
 Direct transmit FIFO write port: frames host strobe cycles and pushes
 each word written with fifo_select, while the FIFO has room, into a small FIFO toward the transmit data store.
 Assumes host strobes, select and data are synchronous to mclk and the
 host keeps its own cycle, pulse and setup minimums.
*/
module txdw_port
    import txdw_pkg::*;
#(
    parameter int ADDR_WIDTH = 5
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic chip_select_n,
    input wire logic write_strobe_n,
    input wire logic fifo_select,
    input wire logic [ADDR_WIDTH-1:0] addr,
    input wire logic [txdw_pkg::DATA_WIDTH-1:0] data_in,
    output logic [txdw_pkg::DATA_WIDTH-1:0] txd_data,
    output logic txd_valid,
    input wire logic txd_ready,
    output logic fifo_can_accept,
    output logic word_dropped,
    output logic reg_write,
    output logic [ADDR_WIDTH-1:0] reg_addr,
    output logic [txdw_pkg::DATA_WIDTH-1:0] reg_data
);
    import txdw_pkg::*;

    // Refuse an empty address field at elaboration
    if (ADDR_WIDTH < 1) begin : g_bad_addr
        $error("txdw_port: ADDR_WIDTH must be at least 1");
    end

    txdw_state_t state_reg, state_next;
    logic [DATA_WIDTH-1:0] data_reg, data_next;
    logic sel_reg, sel_next;
    logic [ADDR_WIDTH-1:0] addr_reg, addr_next;
    logic push_reg, push_next;
    logic drop_reg, drop_next;
    logic regw_reg, regw_next;
    logic [DATA_WIDTH-1:0] regd_reg, regd_next;
    logic [ADDR_WIDTH-1:0] rega_reg, rega_next;
    logic both_low;
    logic push_ready;

    // A cycle exists only while both strobes are low, in whichever order
    assign both_low = !chip_select_n && !write_strobe_n;

    // Framing: capture live data each active cycle, commit on the ending edge
    always_comb begin
        state_next = state_reg;
        data_next = data_reg;
        sel_next = sel_reg;
        addr_next = addr_reg;
        push_next = 1'b0;
        drop_next = 1'b0;
        regw_next = 1'b0;
        regd_next = regd_reg;
        rega_next = rega_reg;
        case (state_reg)
            TXDW_IDLE: begin
                if (both_low) begin
                    state_next = TXDW_ACTIVE;
                    sel_next = fifo_select;
                    addr_next = addr;
                    data_next = data_in;
                end
            end
            TXDW_ACTIVE: begin
                if (both_low) begin
                    // Keep tracking: the word is the one present at the end
                    data_next = data_in;
                    sel_next = sel_reg | fifo_select;
                    addr_next = addr;
                end else begin
                    state_next = TXDW_IDLE;
                    if (sel_reg) begin
                        // Address is ignored; a select write is pushed as a FIFO word if there is room, else dropped
                        if (push_ready) begin
                            push_next = 1'b1;
                        end else begin
                            drop_next = 1'b1;
                        end
                    end else begin
                        regw_next = 1'b1;
                        regd_next = data_reg;
                        rega_next = addr_reg;
                    end
                end
            end
            default: begin
                state_next = TXDW_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_reg <= TXDW_IDLE;
            data_reg <= DATA_RESET;
            sel_reg <= 1'b0;
            addr_reg <= '0;
            push_reg <= 1'b0;
            drop_reg <= 1'b0;
            regw_reg <= 1'b0;
            regd_reg <= DATA_RESET;
            rega_reg <= '0;
        end else begin
            state_reg <= state_next;
            data_reg <= data_next;
            sel_reg <= sel_next;
            addr_reg <= addr_next;
            push_reg <= push_next;
            drop_reg <= drop_next;
            regw_reg <= regw_next;
            regd_reg <= regd_next;
            rega_reg <= rega_next;
        end
    end

    // The push stage reuses data_reg, which holds still while idle
    txdw_fifo #(
        .WIDTH(DATA_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .mclk(mclk),
        .rst(rst),
        .in_data(data_reg),
        .in_valid(push_reg),
        .in_ready(push_ready),
        .out_data(txd_data),
        .out_valid(txd_valid),
        .out_ready(txd_ready)
    );

    // Host has no wait pin, so full is flagged rather than stalled
    assign fifo_can_accept = push_ready;
    assign word_dropped = drop_reg;
    assign reg_write = regw_reg;
    assign reg_addr = rega_reg;
    assign reg_data = regd_reg;
endmodule : txdw_port

// >>> verilog/txdw_pkg.sv
/*
 Shared constants for the direct transmit FIFO write port.
 Assumes one 100 MHz clock and host strobes already synchronous to it.
*/
package txdw_pkg;
    // Clock and host timing figures in nanoseconds
    localparam int CLK_PERIOD_NS = 10;
    localparam int CYCLE_MIN_NS = 165;
    localparam int ACTIVE_MIN_NS = 32;
    localparam int INACTIVE_MIN_NS = 13;
    localparam int DATA_SETUP_NS = 7;
    // Least times round up to whole clock cycles
    localparam int CYCLE_MIN_CLKS = (CYCLE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ACTIVE_MIN_CLKS = (ACTIVE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int INACTIVE_MIN_CLKS = (INACTIVE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Data bus and buffer shape
    localparam int DATA_WIDTH = 16;
    localparam int FIFO_DEPTH = 4;
    localparam logic [DATA_WIDTH-1:0] DATA_RESET = 16'h0000;
    // Port framing states
    typedef enum logic [1:0] {
        TXDW_IDLE,
        TXDW_ACTIVE,
        TXDW_HOLD
    } txdw_state_t;
endpackage : txdw_pkg

// >>> verilog/txdw_fifo.sv
/*
 Small synchronous FIFO with valid and ready on both sides.
 Assumes a single clock and an asynchronous active-high reset.
*/
module txdw_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] DEPTH_CNT = (AW + 1)'(DEPTH);
    localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

    // Refuse shapes the pointer logic cannot serve, at elaboration
    if (DEPTH < 2 || WIDTH < 1) begin : g_bad_shape
        $error("txdw_fifo: DEPTH must be at least 2 and WIDTH at least 1");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_reg, wr_ptr_next;
    logic [AW-1:0] rd_ptr_reg, rd_ptr_next;
    logic [AW:0] count_reg, count_next;
    logic push, pop;

    // Wrap a pointer at the configured depth, which need not be a power of two
    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        return (p == LAST_IDX) ? '0 : p + 1'b1;
    endfunction : bump

    // Honest full and empty straight from the occupancy count
    assign in_ready = (count_reg != DEPTH_CNT);
    assign out_valid = (count_reg != '0);
    assign out_data = mem[rd_ptr_reg];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Pointer and count updates
    always_comb begin
        wr_ptr_next = push ? bump(wr_ptr_reg) : wr_ptr_reg;
        rd_ptr_next = pop ? bump(rd_ptr_reg) : rd_ptr_reg;
        count_next = count_reg;
        if (push && !pop) begin
            count_next = count_reg + 1'b1;
        end else if (pop && !push) begin
            count_next = count_reg - 1'b1;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            count_reg <= count_next;
        end
    end

    // Storage has no reset; words are only read once written
    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end
endmodule : txdw_fifo

// >>> test/txdw_port_props.sv
/* Checker for the direct FIFO write port.
   Sees only the port's pins; bound at the foot. */
module txdw_props
    import txdw_pkg::*;
#(
    parameter int ADDR_WIDTH = 5
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic chip_select_n,
    input wire logic write_strobe_n,
    input wire logic fifo_select,
    input wire logic [ADDR_WIDTH-1:0] addr,
    input wire logic [txdw_pkg::DATA_WIDTH-1:0] data_in,
    input wire logic [txdw_pkg::DATA_WIDTH-1:0] txd_data,
    input wire logic txd_valid,
    input wire logic txd_ready,
    input wire logic fifo_can_accept,
    input wire logic word_dropped,
    input wire logic reg_write,
    input wire logic [ADDR_WIDTH-1:0] reg_addr,
    input wire logic [txdw_pkg::DATA_WIDTH-1:0] reg_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic act_reg;
    logic act_next;
    logic ended;
    // Both strobes low frames a cycle; the edge after it closes it
    always_comb act_next = !chip_select_n && !write_strobe_n;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) act_reg <= 1'h0;
        else act_reg <= act_next;
    end
    assign ended = act_reg && !act_next;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    sequence s_end_sel;
        ended && fifo_select;
    endsequence
    AST_SEL_PUSH: assert property (s_end_sel ##0 fifo_can_accept |-> ##[1:3] txd_valid)
        else $error("select write not queued");
    AST_SEL_NOREG: assert property (s_end_sel |-> ##1 !reg_write [*3])
        else $error("select write reached registers");
    AST_REG_END: assert property (ended && !fifo_select |-> ##[1:2] reg_write)
        else $error("write end missed");
    AST_REG_CAUSE: assert property (reg_write |-> $past(ended) || $past(ended, 2))
        else $error("write without a cycle");
    AST_PULSE: assert property (reg_write |=> !reg_write)
        else $error("write pulse too long");
    AST_DROP_CAUSE: assert property (word_dropped |-> $past(ended) || $past(ended, 2))
        else $error("drop without a cycle");
    AST_FULL_DROP: assert property (s_end_sel ##0 !fifo_can_accept && !txd_ready
        |-> ##[1:2] word_dropped)
        else $error("full drop not flagged");
    AST_HOLD: assert property (txd_valid && !txd_ready |=> txd_valid && $stable(txd_data))
        else $error("head word lost while stalled");
endmodule : txdw_props

bind txdw_port txdw_props #(.ADDR_WIDTH(ADDR_WIDTH)) chk (.*);

// >>> test/txdw_host.sv
/* Host bus master model: strobe writes on the falling edge.
   Assumes the bench calls its tasks one at a time. */
module txdw_host (
    input wire logic mclk,
    output logic chip_select_n,
    output logic write_strobe_n,
    output logic fifo_select,
    output logic [4:0] addr,
    output logic [txdw_pkg::DATA_WIDTH-1:0] data_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle bus at time zero
    initial begin
        chip_select_n = 1'h1;
        write_strobe_n = 1'h1;
        fifo_select = 1'h0;
        addr = 5'h00;
        data_in = 16'h0000;
    end
    // One write of 19 cycles, 40 ns jointly active: margin over the minimums
    task automatic wr(input logic s, input logic [4:0] a, input logic [15:0] d, input logic csf);
        @(negedge mclk);
        fifo_select = s;
        addr = a;
        data_in = d;
        if (csf) chip_select_n = 1'h0;
        else write_strobe_n = 1'h0;
        @(negedge mclk);
        chip_select_n = 1'h0;
        write_strobe_n = 1'h0;
        repeat (4) @(negedge mclk);
        if (csf) chip_select_n = 1'h1;
        else write_strobe_n = 1'h1;
        @(negedge mclk);
        chip_select_n = 1'h1;
        write_strobe_n = 1'h1;
        data_in = ~d; // Released bus shows garbage
        addr = ~a;
        repeat (12) @(negedge mclk);
    endtask : wr
    // Only one strobe low, select follows use_cs: must never count as a write
    task automatic half(input logic use_cs);
        @(negedge mclk);
        fifo_select = use_cs;
        if (use_cs) chip_select_n = 1'h0;
        else write_strobe_n = 1'h0;
        repeat (5) @(negedge mclk);
        chip_select_n = 1'h1;
        write_strobe_n = 1'h1;
        repeat (5) @(negedge mclk);
    endtask : half
endmodule : txdw_host

// >>> test/tx_fifo_direct_write_port_bench.sv
/* Self-checking bench for the direct FIFO write port.
   Host model drives writes; the bench drains the FIFO. */
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin fail_count++; \
    $display("MISMATCH %s expected %h seen %h", n, e, a); end end
module tx_fifo_direct_write_port_bench;
    import txdw_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'h0;
    logic rst = 1'h1;
    logic txd_ready = 1'h0;
    logic cs_n, we_n, sel, txv, can, drop, regw;
    logic [4:0] addr, ra;
    logic [DATA_WIDTH-1:0] din, txd, rd;
    int fail_count = 0;
    int checked = 0;
    int drops = 0;
    int regws = 0;
    always #5 mclk = ~mclk;
    // Count pulses mid-cycle, since they stand one cycle only
    always @(negedge mclk) begin
        if (drop === 1'h1) drops++;
        if (regw === 1'h1) regws++;
    end
    txdw_port dut (.mclk(mclk), .rst(rst), .chip_select_n(cs_n), .write_strobe_n(we_n),
        .fifo_select(sel), .addr(addr), .data_in(din), .txd_data(txd), .txd_valid(txv),
        .txd_ready(txd_ready), .fifo_can_accept(can), .word_dropped(drop), .reg_write(regw),
        .reg_addr(ra), .reg_data(rd));
    txdw_host host (.mclk(mclk), .chip_select_n(cs_n), .write_strobe_n(we_n),
        .fifo_select(sel), .addr(addr), .data_in(din));
    // Pop one word, bounded wait for valid
    task automatic pop(input logic [15:0] e);
        int n;
        n = 0;
        @(negedge mclk);
        while (txv !== 1'h1 && n < 20) begin
            @(negedge mclk);
            n++;
        end
        `CHK("txd_valid", 1'h1, txv)
        `CHK("txd_data", e, txd)
        txd_ready = 1'h1;
        @(negedge mclk);
        txd_ready = 1'h0;
    endtask : pop
    // Five select writes into a stalled 4-deep FIFO: the fifth is refused
    task automatic t_fill;
        for (int i = 0; i < 5; i++) host.wr(1'h1, 5'(i * 7), 16'h1111 * 16'(i + 1), i[0]);
        `CHK("fifo_can_accept", 1'h0, can)
        `CHK("drops", 1, drops)
        for (int i = 0; i < 4; i++) pop(16'h1111 * 16'(i + 1));
        repeat (3) @(negedge mclk);
        `CHK("txd_valid", 1'h0, txv)
        `CHK("regws", 0, regws)
        $display("test fill_and_drain done");
    endtask : t_fill
    // Ordinary write goes to the register side, not the FIFO
    task automatic t_plain;
        host.wr(1'h0, 5'h15, 16'hA5C3, 1'h0);
        `CHK("reg_addr", 5'h15, ra)
        `CHK("reg_data", 16'hA5C3, rd)
        `CHK("regws", 1, regws)
        `CHK("txd_valid", 1'h0, txv)
        $display("test plain_write done");
    endtask : t_plain
    // A single strobe never starts a cycle
    task automatic t_lone;
        host.half(1'h1);
        host.half(1'h0);
        `CHK("regws", 1, regws)
        `CHK("txd_valid", 1'h0, txv)
        $display("test lone_strobe done");
    endtask : t_lone
    task automatic report_and_stop;
        $display("checked %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : report_and_stop
    // Main sequence after 10 reset cycles
    initial begin
        repeat (10) @(negedge mclk);
        rst = 1'h0;
        t_fill;
        t_plain;
        t_lone;
        report_and_stop;
    end
    // Watchdog, about twenty times the expected run
    initial begin
        repeat (3000) @(posedge mclk);
        fail_count++;
        report_and_stop;
    end
endmodule : tx_fifo_direct_write_port_bench
